// ===== fmsc_top.sv
// fmsc_top: selects the sequencer mode and answers data flash reads.
// assumes cmd_valid pulses are commands already accepted by the unit.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - code pe mode: commands on, data unreadable
// - entry data 0, code 1: code pe
// - both entries 0: read mode, no commands
// - data entry rises or normal command: normal
// - normal mode data read: error, lock
// - other command moves to status read
// - status read covers busy and locked
// - status read returns status register 0
// - lock read command enters lock-bit read
// - lock-bit read: undefined data, no error
// - lock-bit read keeps code fast read
module fmsc_top
	import fmsc_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              clk_en,
	input  wire logic [7:0]        pe_entry_register,
	input  wire logic              cmd_valid,
	input  wire logic [7:0]        cmd_code,
	input  wire logic              flash_ready_flag,
	input  wire logic              unlock,
	input  wire fmsc_rd_req_t      rd_req,
	output var  fmsc_rd_rsp_t      rd_rsp,
	output var  fmsc_mode_t        mode_q,
	output var  logic              cmd_enable_q,
	output var  logic              code_fast_read_q,
	output var  logic              cmd_locked_q,
	output var  logic [7:0]        flash_status_reg0_q
);
	fmsc_mode_t        mode_d;
	logic              ent_data;
	logic              ent_code;
	logic              ent_data_prev_q;
	logic              data_rise;
	logic              rd_fire;
	logic              lock_err;
	logic              locked_d;
	logic [DATA_W-1:0] arr_rdata;
	logic              rd_pend_q;
	fmsc_mode_t        rd_mode_q;
	logic [7:0]        stat_d;
	fmsc_rd_rsp_t      rsp_d;
	logic              ce_arr;

	assign ent_data  = pe_entry_register[ENT_DATA_BIT];
	assign ent_code  = pe_entry_register[ENT_CODE_BIT];
	assign data_rise = ent_data & ~ent_data_prev_q;
	assign rd_fire   = rd_req.valid;
	assign ce_arr    = clk_en & rd_fire;

	// data read in normal mode locks the unit
	assign lock_err = rd_fire & (mode_q == FMSC_DNORMAL);
	// locked state sets even if unlock is seen the same cycle
	assign locked_d = lock_err | (cmd_locked_q & ~unlock);
	// status: ready flag plus lock indication
	assign stat_d   = {flash_ready_flag, 2'b00, locked_d, 4'h0};

	always_comb
	begin
		mode_d = mode_q;
		if (!ent_data && !ent_code)
			mode_d = FMSC_READ;
		else if (!ent_data && ent_code)
			mode_d = FMSC_CODE_PE;
		else if (ent_data && !ent_code)
		begin
			// entry from read or code pe
			if (data_rise || mode_q == FMSC_READ ||
				mode_q == FMSC_CODE_PE)
				mode_d = FMSC_DNORMAL;
			else if (lock_err)
				mode_d = FMSC_DSTATUS;
			else if (cmd_valid)
			begin
				if (cmd_code == CMD_NORMAL)
					mode_d = FMSC_DNORMAL;
				else if (cmd_code == CMD_LOCKREAD)
					mode_d = FMSC_DLOCKRD;
				else
					mode_d = FMSC_DSTATUS;
			end
		end
	end

	fmsc_array #(.DEPTH(16)) u_array
	(
		.ref_clk (ref_clk),
		.ce      (ce_arr),
		.addr    (rd_req.addr),
		.rdata   (arr_rdata)
	);

	always_comb
	begin
		rsp_d = '0;
		rsp_d.valid = rd_pend_q;
		unique case (rd_mode_q)
			FMSC_READ:    rsp_d.data = arr_rdata;
			FMSC_DSTATUS: rsp_d.data = {8'h00, flash_status_reg0_q};
			FMSC_DLOCKRD: rsp_d.data = UNDEF_DATA;
			// array not readable in code pe
			FMSC_CODE_PE: rsp_d.err  = rd_pend_q;
			FMSC_DNORMAL: rsp_d.err  = rd_pend_q;
			default:      rsp_d.err  = rd_pend_q;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (!rst_n)
		begin
			mode_q              <= FMSC_READ;
			ent_data_prev_q     <= 1'b0;
			cmd_locked_q        <= 1'b0;
			flash_status_reg0_q <= 8'h00;
			rd_pend_q           <= 1'b0;
			rd_mode_q           <= FMSC_READ;
			rd_rsp              <= '0;
			cmd_enable_q        <= 1'b0;
			code_fast_read_q    <= 1'b1;
		end
		else if (clk_en)
		begin
			mode_q              <= mode_d;
			ent_data_prev_q     <= ent_data;
			cmd_locked_q        <= locked_d;
			flash_status_reg0_q <= stat_d;
			rd_pend_q           <= rd_fire;
			rd_mode_q           <= mode_q;
			rd_rsp              <= rsp_d;
			cmd_enable_q        <= (mode_d != FMSC_READ);
			// fast code read in read and lock-bit read
			code_fast_read_q    <= (mode_d == FMSC_READ) ||
				(mode_d == FMSC_DLOCKRD);
		end
	end

	// assertions
	a_code_pe_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !ent_data && ent_code |=> mode_q == FMSC_CODE_PE)
		else $error("code pe not entered");
	a_read_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !ent_data && !ent_code |=> mode_q == FMSC_READ &&
		!cmd_enable_q)
		else $error("read mode wrong");
	a_normal_lock: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && lock_err |=> cmd_locked_q && mode_q != FMSC_DNORMAL)
		else $error("lock missing");
	a_other_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && ent_data && !ent_code && !data_rise && !lock_err &&
		cmd_valid && cmd_code != CMD_NORMAL && cmd_code != CMD_LOCKREAD &&
		mode_q inside {FMSC_DNORMAL, FMSC_DSTATUS, FMSC_DLOCKRD}
		|=> mode_q == FMSC_DSTATUS)
		else $error("status mode not entered");
	a_lockrd_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && ent_data && !ent_code && !data_rise && !lock_err &&
		cmd_valid && cmd_code == CMD_LOCKREAD &&
		mode_q inside {FMSC_DNORMAL, FMSC_DSTATUS, FMSC_DLOCKRD}
		|=> mode_q == FMSC_DLOCKRD)
		else $error("lock read not entered");
	a_status_data: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_fire && mode_q == FMSC_DSTATUS ##1 clk_en
		|=> rd_rsp.valid && !rd_rsp.err &&
		rd_rsp.data[7:0] == $past(flash_status_reg0_q))
		else $error("status data wrong");
	a_lockrd_noerr: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_fire && mode_q == FMSC_DLOCKRD ##1 clk_en
		|=> rd_rsp.valid && !rd_rsp.err)
		else $error("lock read error");
	a_code_pe_noread: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && rd_fire && mode_q == FMSC_CODE_PE ##1 clk_en
		|=> rd_rsp.err)
		else $error("code pe read allowed");
	a_fast_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && mode_d == FMSC_DLOCKRD |=> code_fast_read_q)
		else $error("fast read lost");
	a_data_entry: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && ent_data && !ent_code &&
		mode_q inside {FMSC_READ, FMSC_CODE_PE} |=> mode_q == FMSC_DNORMAL)
		else $error("normal not entered");
	a_busy_status: assert property (@(posedge ref_clk) disable iff (!rst_n)
		clk_en && !flash_ready_flag |=> !flash_status_reg0_q[RDY_BIT])
		else $error("busy not shown");

	c_lock: cover property (@(posedge ref_clk) clk_en && lock_err);
	c_status: cover property (@(posedge ref_clk) mode_q == FMSC_DSTATUS);
	c_lockrd: cover property (@(posedge ref_clk) mode_q == FMSC_DLOCKRD);
endmodule // fmsc_top
`default_nettype wire

// ===== fmsc_pkg.sv
// fmsc_pkg: shared types and constants for the flash mode state control.
// assumes a single peripheral clock and a synchronous active-low reset.
package fmsc_pkg;

	localparam int DATA_W = 16;
	localparam int ADDR_W = 16;

	// command codes as seen by the mode logic
	localparam logic [7:0] CMD_NORMAL   = 8'hFF;
	localparam logic [7:0] CMD_LOCKREAD = 8'h71;

	// read-back value while data flash holds no defined contents
	localparam logic [DATA_W-1:0] UNDEF_DATA = 16'hFFFF;

	// entry bit positions within pe_entry_register
	localparam int ENT_CODE_BIT = 0;
	localparam int ENT_DATA_BIT = 7;

	// flash_status_reg0: ready flag position
	localparam int RDY_BIT = 7;

	typedef enum logic [5:0] {
		FMSC_READ     = 6'h01,
		FMSC_CODE_PE  = 6'h02,
		FMSC_DNORMAL  = 6'h04,
		FMSC_DSTATUS  = 6'h08,
		FMSC_DLOCKRD  = 6'h10,
		FMSC_UNUSED   = 6'h20
	} fmsc_mode_t;

	typedef struct packed {
		logic               valid;
		logic [ADDR_W-1:0]  addr;
	} fmsc_rd_req_t;

	typedef struct packed {
		logic               valid;
		logic [DATA_W-1:0]  data;
		logic               err;
	} fmsc_rd_rsp_t;

endpackage : fmsc_pkg

// ===== fmsc_array.sv
// fmsc_array: small data flash array model with registered read data.
// assumes the sequencer handles all programming; read only here.
`timescale 1ns/1ns
`default_nettype none
module fmsc_array
	import fmsc_pkg::*;
#(
	parameter int DEPTH = 16
)
(
	input  wire logic              ref_clk,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] addr,
	output var  logic [DATA_W-1:0] rdata
);
	logic [DATA_W-1:0] mem [DEPTH];

	genvar gi;
	generate
		for (gi = 0; gi < DEPTH; gi++)
		begin : g_init
			// erased cells read as all ones
			assign mem[gi] = UNDEF_DATA;
		end
	endgenerate

	always_ff @(posedge ref_clk)
	begin
		if (ce)
			rdata <= mem[addr[$clog2(DEPTH)-1:0]];
	end
endmodule // fmsc_array
`default_nettype wire

// ===== fmsc_cpu_model.sv
// fmsc_cpu_model: processor side, drives entry bits, commands and reads.
// assumes the bench calls its tasks; drives on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module fmsc_cpu_model
	import fmsc_pkg::*;
(
	input  wire logic         ref_clk,
	input  wire fmsc_rd_rsp_t rd_rsp,
	output var  logic [7:0]   pe_entry_register,
	output var  logic         cmd_valid,
	output var  logic [7:0]   cmd_code,
	output var  fmsc_rd_req_t rd_req
);
	initial
	begin
		pe_entry_register = 8'h00;
		cmd_valid = 1'b0;
		cmd_code = 8'h00;
		rd_req = '0;
	end

	// idle code is inverted so a stale value differs from the last code; after code 8'h00 it reads as CMD_NORMAL
	task automatic put(input logic [7:0] e, input logic v,
		input logic [7:0] c);
		@(negedge ref_clk);
		pe_entry_register = e;
		cmd_valid = v;
		cmd_code = c;
		@(negedge ref_clk);
		cmd_valid = 1'b0;
		cmd_code = ~c;
	endtask

	task automatic read(input logic [15:0] a, output fmsc_rd_rsp_t r);
		r = '0;
		@(negedge ref_clk);
		rd_req = {1'b1, a};
		@(negedge ref_clk);
		rd_req = {1'b0, ~a};
		repeat (3)
		begin
			@(negedge ref_clk);
			if (rd_rsp.valid === 1'b1)
				r = rd_rsp;
		end
	endtask
endmodule // fmsc_cpu_model
`default_nettype wire

// ===== tb.sv
// tb: table of mode steps, then hand tests of reads, lock and freeze.
// assumes fmsc_top and fmsc_cpu_model; ref_clk at 25 MHz.
`timescale 1ns/1ns
`default_nettype none
module tb;
	import fmsc_pkg::*;
	typedef struct packed {
		logic [7:0] ent;
		logic       cv;
		logic [7:0] cc;
		fmsc_mode_t m;
	} fmsc_row_t;
	logic         ref_clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         clk_en = 1'b1;
	logic         rdy = 1'b1;
	logic         unlock = 1'b0;
	logic [7:0]   ent;
	logic         cv;
	logic [7:0]   cc;
	logic [7:0]   st;
	logic         en;
	logic         fast;
	logic         lock;
	fmsc_rd_req_t req;
	fmsc_rd_rsp_t rsp;
	fmsc_rd_rsp_t got;
	fmsc_mode_t   mode;
	int           n_errors = 0;
	int           checked = 0;
	int           cyc = 0;
	fmsc_row_t rows [9] = '{
		'{8'h01, 1'b0, 8'h00, FMSC_CODE_PE},
		'{8'h80, 1'b0, 8'h00, FMSC_DNORMAL},
		'{8'h80, 1'b1, 8'hE8, FMSC_DSTATUS},
		'{8'h80, 1'b1, 8'hFF, FMSC_DNORMAL},
		'{8'h80, 1'b1, 8'h71, FMSC_DLOCKRD},
		'{8'h80, 1'b1, 8'hFF, FMSC_DNORMAL},
		'{8'h00, 1'b0, 8'h00, FMSC_READ},
		'{8'h80, 1'b0, 8'h00, FMSC_DNORMAL},
		'{8'h81, 1'b0, 8'h00, FMSC_DNORMAL}};

	fmsc_cpu_model i_cpu (.ref_clk(ref_clk), .rd_rsp(rsp),
		.pe_entry_register(ent), .cmd_valid(cv), .cmd_code(cc),
		.rd_req(req));
	fmsc_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
		.pe_entry_register(ent), .cmd_valid(cv), .cmd_code(cc),
		.flash_ready_flag(rdy), .unlock(unlock), .rd_req(req),
		.rd_rsp(rsp), .mode_q(mode), .cmd_enable_q(en),
		.code_fast_read_q(fast), .cmd_locked_q(lock),
		.flash_status_reg0_q(st));

	always #20 ref_clk = ~ref_clk;

	task automatic results();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		checked++;
		if (g !== e)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_mode(input fmsc_mode_t m);
		chk("mode", {10'h000, m}, {10'h000, mode});
		chk("cmd_enable", {15'h0000, m != FMSC_READ}, {15'h0000, en});
		chk("fast_read", {15'h0000, m == FMSC_READ || m == FMSC_DLOCKRD},
			{15'h0000, fast});
	endtask

	task automatic rd(input logic [15:0] a);
		i_cpu.read(a, got);
		chk("rsp_valid", 16'h0001, {15'h0000, got.valid});
	endtask

	always @(posedge ref_clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_errors++;
			results();
		end
	end

	initial
	begin
		repeat (6) @(negedge ref_clk);
		chk_mode(FMSC_READ);
		rst_n = 1'b1;
		foreach (rows[i])
		begin
			i_cpu.put(rows[i].ent, rows[i].cv, rows[i].cc);
			chk_mode(rows[i].m);
		end
		i_cpu.put(8'h00, 1'b0, 8'h00);
		rd(16'h0004);
		chk("read_err", 16'h0000, {15'h0000, got.err});
		chk("read_data", UNDEF_DATA, got.data);
		i_cpu.put(8'h01, 1'b0, 8'h00);
		rd(16'h0006);
		chk("code_pe_err", 16'h0001, {15'h0000, got.err});
		i_cpu.put(8'h80, 1'b0, 8'h00);
		i_cpu.put(8'h80, 1'b1, CMD_LOCKREAD);
		rd(16'h0008);
		chk("lock_rd_data", UNDEF_DATA, got.data);
		chk("lock_rd_err", 16'h0000, {15'h0000, got.err});
		chk_mode(FMSC_DLOCKRD);
		i_cpu.put(8'h80, 1'b1, CMD_NORMAL);
		rd(16'h000A);
		chk("normal_err", 16'h0001, {15'h0000, got.err});
		@(negedge ref_clk);
		chk_mode(FMSC_DSTATUS);
		chk("locked", 16'h0001, {15'h0000, lock});
		chk("status_reg", 16'h0090, {8'h00, st});
		rd(16'h000C);
		chk("status_rd", 16'h0090, {8'h00, got.data[7:0]});
		rdy = 1'b0;
		unlock = 1'b1;
		@(negedge ref_clk);
		unlock = 1'b0;
		@(negedge ref_clk);
		rd(16'h000E);
		chk("busy_rd", 16'h0000, {8'h00, got.data[7:0]});
		chk("status_reg", 16'h0000, {8'h00, st});
		chk("locked", 16'h0000, {15'h0000, lock});
		chk_mode(FMSC_DSTATUS);
		clk_en = 1'b0;
		i_cpu.put(8'h00, 1'b0, 8'h00);
		chk_mode(FMSC_DSTATUS);
		clk_en = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk_mode(FMSC_READ);
		results();
	end
endmodule // tb
`default_nettype wire
